// *** dv/exec_checker.sv ***
`timescale 1ns/10ps
// Purpose: port checker for the execute block
// Assumes: inputs settle before the rising edge
// Notes: t marks a word that is taken
module exec_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire exec_pkg::insn_t insn,
  input wire logic [7:0] file_rdata,
  input wire exec_pkg::file_wr_t file_wr,
  input wire logic [7:0] accumulator,
  input wire logic zero_flag,
  input wire logic skip_taken,
  input wire logic insn_done
);
  import exec_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire t = insn.valid & !skip_taken;
  wire [5:0] op = insn.word[13:8];
  a_lit_load: assert property (t && op[5:2] == 4'hc |=>
    accumulator == $past(insn.word[7:0]) && $stable(zero_flag)) else $error("lit load");
  a_orlit_acc: assert property (t && op == OP_ORLIT |=>
    accumulator == ($past(accumulator) | $past(insn.word[7:0]))) else $error("or lit");
  a_zero_flag: assert property (
    t && (op == OP_ORLIT || op == OP_ORWF && !insn.word[7]) |=>
    zero_flag == (accumulator == 8'h00)) else $error("zero");
  a_orwf_acc: assert property (t && op == OP_ORWF && !insn.word[7] |=> !file_wr.wr &&
    accumulator == ($past(accumulator) | $past(file_rdata))) else $error("or w");
  a_orwf_file: assert property (t && op == OP_ORWF && insn.word[7] |=> file_wr.wr &&
    file_wr.data == ($past(accumulator) | $past(file_rdata))
    && file_wr.addr == $past(insn.word[6:0])) else $error("or f");
  a_incf_file: assert property (t && op == OP_INCSKIP && insn.word[7] |=>
    file_wr.wr && file_wr.data == $past(file_rdata) + 8'h01
    && file_wr.addr == $past(insn.word[6:0])) else $error("inc f");
  a_incf_acc: assert property (t && op == OP_INCSKIP && !insn.word[7] |=>
    !file_wr.wr && accumulator == $past(file_rdata) + 8'h01) else $error("inc w");
  a_done_one: assert property (t && op == OP_INCSKIP && file_rdata != 8'hff |=>
    insn_done && !skip_taken) else $error("no skip length");
  a_incf_skip: assert property (t && op == OP_INCSKIP |=>
    skip_taken == ($past(file_rdata) == 8'hff) && $stable(zero_flag)) else $error("skip");
  a_skip_len: assert property (skip_taken |-> !insn_done ##1 insn_done)
    else $error("skip length");
endmodule
bind incr_skip_or_literal_exec exec_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .insn(insn), .file_rdata(file_rdata), .file_wr(file_wr), .accumulator(accumulator),
  .zero_flag(zero_flag), .skip_taken(skip_taken), .insn_done(insn_done));

// *** dv/file_model.sv ***
`timescale 1ns/10ps
// Purpose: file register array beside the block
// Assumes: read is combinational on the offered word
// Notes: writes land at the edge after file_wr
module file_model (
  input wire logic core_clk,
  input wire exec_pkg::insn_t insn,
  input wire exec_pkg::file_wr_t file_wr,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [128] = '{default: 8'h00};
  assign file_rdata = mem[insn.word[6:0]];
  always @(posedge core_clk) begin
    if (file_wr.wr) mem[file_wr.addr] <= file_wr.data;
  end
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
// Purpose: directed bench for the execute block
// Assumes: inputs change on the falling edge
// Notes: file array lives in the partner model
module testbench;
  import exec_pkg::*;
  logic core_clk = 0;
  logic sys_rst = 1;
  insn_t insn = '0;
  logic [7:0] file_rdata;
  logic [6:0] file_raddr;
  file_wr_t file_wr;
  logic [7:0] accumulator;
  logic zero_flag, skip_taken, insn_done;
  int num_checks = 0;
  int n_mismatch = 0;
  always #25 core_clk = ~core_clk;
  incr_skip_or_literal_exec dut (.core_clk(core_clk), .sys_rst(sys_rst), .insn(insn),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr),
    .accumulator(accumulator),
    .zero_flag(zero_flag), .skip_taken(skip_taken), .insn_done(insn_done));
  file_model fm (.core_clk(core_clk), .insn(insn), .file_wr(file_wr), .file_rdata(file_rdata));
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task put(input logic [13:0] w);
    @(negedge core_clk);
    insn = {1'b1, w};
  endtask
  task idle;
    @(negedge core_clk);
    insn.valid = 1'b0;
  endtask
  task t_lit;
    put(14'h335a);
    idle;
    chk(accumulator, 8'h5a);
    put(14'h329a);
    put(14'h3835);
    idle;
    chk(accumulator, 8'hbf);
    put(14'h3100);
    put(14'h3800);
    idle;
    chk(8'(zero_flag), 8'h01);
    put(14'h0a05);
    idle;
    chk(accumulator, 8'h00);
  endtask
  task t_orwf;
    fm.mem[3] = 8'h13;
    put(14'h3291);
    put(14'h0403);
    idle;
    chk(accumulator, 8'h93);
    chk(8'(file_raddr), 8'h03);
    chk(8'(zero_flag), 8'h00);
    put(14'h3104);
    put(14'h0483);
    idle;
    idle;
    chk(fm.mem[3], 8'h17);
  endtask
  task t_skip;
    fm.mem[5] = 8'hff;
    put(14'h3342);
    put(14'h0f85);
    put(14'h3377);
    chk(8'(skip_taken), 8'h01);
    chk(8'(insn_done), 8'h00);
    idle;
    chk(8'(insn_done), 8'h01);
    chk(accumulator, 8'h42);
    chk(fm.mem[5], 8'h00);
    put(14'h0f05);
    idle;
    chk(accumulator, 8'h01);
    chk(8'(skip_taken), 8'h00);
    chk(8'(insn_done), 8'h01);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    sys_rst = 0;
    t_lit;
    t_orwf;
    t_skip;
    give_verdict;
  end
endmodule

// *** inc/exec_pkg.sv ***
// Purpose: shared constants and types for the four-instruction execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes: none
//
// Functional notes
// - increment file, destination by d, flags untouched
// - decode 00 1111 d fffffff as increment-skip
// - zero result discards prefetched word as no_operation
// - one word, one cycle, two when skipping
// - or w with file, route by d, update zero
// - decode 00 0100 d fffffff as or-with-file
// - load literal into accumulator, flags untouched
// - bits 9 and 8 ignored for move literal
// - or literal into accumulator, update zero
package exec_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [5:0] OP_INCSKIP = 6'h0f;
  localparam logic [5:0] OP_ORWF = 6'h04;
  localparam logic [3:0] OP_MOVLIT = 4'hc;
  localparam logic [5:0] OP_ORLIT = 6'h38;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam int DEST_BIT = 7;

  typedef struct packed {
    logic valid;
    logic [INSN_W-1:0] word;
  } insn_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_wr_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } exec_state_t;
endpackage

// *** src/file_read_reg.sv ***
`timescale 1ns/10ps
// Purpose: load-enabled byte register with a registered output
// Assumes: din is settled before the edge at which load is high
// Notes: holds the working register of the execute block
module file_read_reg (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // capture
  input wire logic load,
  input wire logic [exec_pkg::DATA_W-1:0] din,
  output logic [exec_pkg::DATA_W-1:0] dout
);
  import exec_pkg::*;
  logic [DATA_W-1:0] next_dout;

  always_comb begin
    next_dout = load ? din : dout;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dout <= ACC_RESET;
    end else begin
      dout <= next_dout;
    end
  end
endmodule

// *** src/incr_skip_or_literal_exec.sv ***
`timescale 1ns/10ps
// Purpose: decode and execute of increment-skip, or-with-file, move and or literal
// Assumes: one instruction word offered per cycle; file read is combinational
// Notes: unknown opcodes execute as no_operation
//   the working register lives in a load-enabled byte register
module incr_skip_or_literal_exec (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // instruction from fetch
  input wire exec_pkg::insn_t insn,
  // file register read port
  output logic [exec_pkg::ADDR_W-1:0] file_raddr,
  input wire logic [exec_pkg::DATA_W-1:0] file_rdata,
  // file register write port
  output exec_pkg::file_wr_t file_wr,
  // architectural state
  output logic [exec_pkg::DATA_W-1:0] accumulator,
  output logic zero_flag,
  // sequencing
  output logic skip_taken,
  output logic insn_done
);
  import exec_pkg::*;

  // ==========================================
  // decode
  logic [5:0] op6;
  logic is_incskip;
  logic is_orwf;
  logic is_movlit;
  logic is_orlit;
  logic dest_file;
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] literal;

  assign op6 = insn.word[INSN_W-1:INSN_W-6];
  assign is_incskip = insn.valid && (op6 == OP_INCSKIP);
  assign is_orwf = insn.valid && (op6 == OP_ORWF);
  // low two opcode bits are don't-care for move literal
  assign is_movlit = insn.valid && (op6[5:2] == OP_MOVLIT);
  assign is_orlit = insn.valid && (op6 == OP_ORLIT);
  // anything else falls through as no_operation
  assign dest_file = insn.word[DEST_BIT];
  assign faddr = insn.word[ADDR_W-1:0];
  assign literal = insn.word[DATA_W-1:0];

  // ==========================================
  // operands and results
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] sum;
  logic [DATA_W-1:0] orres;
  logic [DATA_W-1:0] orlit_res;
  logic sum_zero;
  logic orres_zero;
  logic orlit_zero;

  function automatic logic is_zero_byte(input logic [DATA_W-1:0] value);
    return value == 8'h00;
  endfunction

  // file data follows the word on insn in the same cycle
  assign operand = file_rdata;
  // increment wraps in eight bits
  assign sum = DATA_W'(operand + 8'h01);
  assign orres = accumulator | operand;
  assign orlit_res = accumulator | literal;
  assign sum_zero = is_zero_byte(sum);
  assign orres_zero = is_zero_byte(orres);
  assign orlit_zero = is_zero_byte(orlit_res);

  // ==========================================
  // sequencer
  exec_state_t state;
  exec_state_t next_state;
  logic take;
  logic skip_now;
  logic next_skip;
  logic next_done;

  // the word offered in the flush cycle is the one fetched behind
  // the skip; it must not touch any state
  assign take = (state == ST_EXEC) && insn.valid;
  assign skip_now = take && is_incskip && sum_zero;

  always_comb begin
    next_state = state;
    next_skip = 1'b0;
    next_done = 1'b0;
    unique case (state)
      ST_EXEC: begin
        if (skip_now) begin
          // zero result: done waits for the flush cycle
          next_state = ST_FLUSH;
          next_skip = 1'b1;
          next_done = 1'b0;
        end else begin
          next_done = insn.valid;
        end
      end
      ST_FLUSH: begin
        // prefetched word dropped, no_operation in its place
        next_state = ST_EXEC;
        next_done = 1'b1;
      end
      // one-hot codes; any other code falls back to ST_EXEC
      default: begin
        next_state = ST_EXEC;
      end
    endcase
  end

  // skip_taken is a one-cycle pulse; insn_done is high one cycle per finished word, so it stays high for back-to-back words
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_EXEC;
      skip_taken <= 1'b0;
      insn_done <= 1'b0;
    end else begin
      state <= next_state;
      skip_taken <= next_skip;
      insn_done <= next_done;
    end
  end

  // ==========================================
  // accumulator
  logic [DATA_W-1:0] next_acc;

  // a file destination leaves the working register as it was
  always_comb begin
    next_acc = accumulator;
    if (take) begin
      if (is_incskip && !dest_file) begin
        next_acc = sum;
      end else if (is_orwf && !dest_file) begin
        next_acc = orres;
      end else if (is_movlit) begin
        next_acc = literal;
      end else if (is_orlit) begin
        next_acc = orlit_res;
      end
    end
  end

  // the working register sits in a load-enabled byte register
  file_read_reg acc_hold (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(take),
    .din(next_acc),
    .dout(accumulator)
  );

  // ==========================================
  // zero flag
  logic next_zero;

  // increment-skip and move literal leave the flag alone
  always_comb begin
    next_zero = zero_flag;
    if (take) begin
      // the flag follows the result, whatever its destination
      if (is_orwf) begin
        next_zero = orres_zero;
      end else if (is_orlit) begin
        next_zero = orlit_zero;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_flag <= ZERO_RESET;
    end else begin
      zero_flag <= next_zero;
    end
  end

  // ==========================================
  // file read address
  logic [ADDR_W-1:0] next_raddr;

  // registered copy of the offered address, for observation only
  always_comb begin
    next_raddr = faddr;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      file_raddr <= '0;
    end else begin
      file_raddr <= next_raddr;
    end
  end

  // ==========================================
  // file register write port
  file_wr_t next_file_wr;

  // only file destinations raise a write
  always_comb begin
    next_file_wr = '0;
    if (take && dest_file) begin
      if (is_incskip) begin
        next_file_wr.wr = 1'b1;
        next_file_wr.addr = faddr;
        next_file_wr.data = sum;
      end else if (is_orwf) begin
        next_file_wr.wr = 1'b1;
        next_file_wr.addr = faddr;
        next_file_wr.data = orres;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      file_wr <= '0;
    end else begin
      file_wr <= next_file_wr;
    end
  end
endmodule
